//--- rtl/spsa_defines.svh
// Offsets, field positions, reset values and counts of the serial port
`ifndef SPSA_DEFINES_SVH
`define SPSA_DEFINES_SVH

// ==========================================================================
// Register offsets
`define SPSA_OFF_CTL      8'h00
`define SPSA_OFF_BUF      8'h01
`define SPSA_OFF_CFG      8'h02

// ==========================================================================
// Control register fields
`define SPSA_CTL_MSH      7
`define SPSA_CTL_MSL      6
`define SPSA_CTL_OPT      5
`define SPSA_CTL_REN      4
`define SPSA_CTL_TB8      3
`define SPSA_CTL_RB8      2
`define SPSA_CTL_TI       1
`define SPSA_CTL_RI       0
`define SPSA_CTL_RST      8'h00

// Config register: bit 0 selects the faster baud divider
`define SPSA_CFG_FAST     0
`define SPSA_CFG_RST      1'b1

// ==========================================================================
// Timing counts
`define SPSA_M0_DIV_SLOW  12
`define SPSA_M0_DIV_FAST  4
`define SPSA_SAMPLES      16
`define SPSA_SAMPLE_A     7
`define SPSA_SAMPLE_B     8
`define SPSA_SAMPLE_C     9
`define SPSA_BITS_M0      8
`define SPSA_FRAME_10     10
`define SPSA_FRAME_11     11

`endif

//--- rtl/spsa_pkg.sv
// Types of the serial port
package spsa_pkg;

    // ======================================================================
    // Modes and state machines
    typedef enum logic [1:0] {
        SPSA_MODE_SYNC  = 2'h0,
        SPSA_MODE_A10   = 2'h1,
        SPSA_MODE_A11F  = 2'h2,
        SPSA_MODE_A11T  = 2'h3
    } spsa_mode_type;

    typedef enum logic [2:0] {
        SPSA_TX_IDLE = 3'h1,
        SPSA_TX_WAIT = 3'h2,
        SPSA_TX_SEND = 3'h4
    } spsa_tx_type;

    typedef enum logic [1:0] {
        SPSA_RX_HUNT = 2'h1,
        SPSA_RX_BITS = 2'h2
    } spsa_rx_type;

    // ======================================================================
    // Whole state of the block
    typedef struct packed {
        spsa_mode_type mode;
        logic          opt;
        logic          ren;
        logic          tb8;
        logic          rb8;
        logic          ti;
        logic          ri;
        logic          fast;
        logic [7:0]    rbuf;
        logic [7:0]    rdata;
        logic          sy1;
        logic          sy2;
        logic          sy3;
        logic          m0_act;
        logic          m0_tx;
        logic [3:0]    m0_cnt;
        logic [2:0]    m0_bit;
        logic [7:0]    m0_sh;
        logic          sclk;
        logic          rxd_o;
        logic          rxd_oe;
        logic [1:0]    pre;
        logic          half;
        spsa_tx_type   txst;
        logic [3:0]    tx_div;
        logic [10:0]   tx_sh;
        logic [3:0]    tx_left;
        logic          txd;
        logic          txd_pin;
        spsa_rx_type   rxst;
        logic [3:0]    rx_div;
        logic [3:0]    rx_idx;
        logic [1:0]    rx_s;
        logic [7:0]    rx_sh;
        logic          rx9;
    } spsa_state_type;

endpackage : spsa_pkg

//--- rtl/spsa_serial_port.sv
// Serial port with synchronous shift mode and asynchronous frame modes
//
// How it works
// - Two mode bits pick sync 8-bit, async 10-bit, async 11-bit fixed or timer baud.
// - Writing the serial buffer starts a transmission in every mode.
// - Mode 0 receive starts when receive done is 0 and receive enable is 1.
// - Async receive starts only with enable set and an incoming start bit.
// - Mode 0 moves data both ways on receive pin; transmit pin is shift clock.
// - Mode 0 frame is eight data bits, LSB first, no start or stop.
// - Mode 0 shift clock is system clock /12, or /4 with option bit set.
// - Mode 0 transmit starts next clock, shifts right on falling shift clock.
// - After eight mode 0 bits sent, send ends and transmit done is set.
// - Mode 0 receive starts next clock, latches pin on rising shift clock.
// - After eight bits received, receive done set; no restart until cleared.
// - Mode 1 frame: start 0, eight data LSB first, stop 1 to ninth bit field.
// - Mode 1 bit rate is timer overflow rate /16, or /32 alternative.
// - Mode 1 transmit starts on clock after next divide-by-16 rollover.
// - Transmit sends start, data, stop; transmit done set as stop goes out.
// - Receive samples at 16x baud; falling edge resets the divide counter.
// - Bit value is majority of samples at counter states 7, 8 and 9.
// - A start bit read as 1 aborts reception and hunts for another edge.
// - Frame loads buffer only if done flag 0 and option 0 or stop 1 (ninth bit 1 in 11-bit modes).
// - After each async frame receiver hunts again; software clears done flag.
//
// The plain strobed port and the placing of the registers were left to the implementer.
`timescale 1ns/1ps
`default_nettype none
`include "spsa_defines.svh"

module spsa_serial_port #(
    parameter int AW = 8
) (
    // Clock and reset
    input  wire logic          i_clk,
    input  wire logic          i_rst_n,
    // Register port
    input  wire logic [AW-1:0] i_addr,
    input  wire logic [7:0]    i_wdata,
    input  wire logic          i_wr,
    input  wire logic          i_rd,
    output logic      [7:0]    o_rdata,
    // Baud timer overflow pulse, same clock
    input  wire logic          i_timer_ovf,
    // Serial pins
    input  wire logic          i_rxd,
    output logic               o_rxd,
    output logic               o_rxd_oe,
    output logic               o_txd,
    // Mode reported to the system
    output spsa_pkg::spsa_mode_type o_mode
);
    import spsa_pkg::*;

    // ======================================================================
    // Elaboration checks
    if (AW < 2) begin : g_bad_aw
        $error("AW must be at least 2");
    end

    // Dividers and bit indexes share 4-bit counters
    if (`SPSA_M0_DIV_SLOW > 16) begin : g_bad_slow
        $error("Slow divider exceeds counter");
    end
    if (`SPSA_M0_DIV_FAST < 4) begin : g_bad_fast
        $error("Fast divider under synchroniser delay");
    end
    if (`SPSA_SAMPLE_C >= `SPSA_SAMPLES) begin : g_bad_smp
        $error("Sample points outside bit time");
    end
    if (`SPSA_FRAME_11 > 16) begin : g_bad_frame
        $error("Frame exceeds bit index");
    end

    // ======================================================================
    // State
    spsa_state_type r;
    spsa_state_type n;

    logic       wr_ctl;
    logic       wr_buf;
    logic       wr_cfg;
    logic       tick;
    logic       roll;
    logic       ti_set;
    logic       ri_set;
    logic       sync_m;
    logic       bitv;
    logic       keep;
    logic [3:0] m0_last;
    logic [3:0] m0_half;
    logic [3:0] rx_last;
    logic [7:0] rev;

    always_comb begin
        n       = r;
        ti_set  = 1'b0;
        ri_set  = 1'b0;
        bitv    = 1'b0;
        keep    = 1'b0;
        rev     = 8'h00;
        wr_ctl  = i_wr && (i_addr == AW'(`SPSA_OFF_CTL));
        wr_buf  = i_wr && (i_addr == AW'(`SPSA_OFF_BUF));
        wr_cfg  = i_wr && (i_addr == AW'(`SPSA_OFF_CFG));
        sync_m  = (r.mode == SPSA_MODE_SYNC);
        m0_last = r.opt ? 4'(`SPSA_M0_DIV_FAST - 1) : 4'(`SPSA_M0_DIV_SLOW - 1);
        m0_half = r.opt ? 4'(`SPSA_M0_DIV_FAST / 2) : 4'(`SPSA_M0_DIV_SLOW / 2);
        rx_last = (r.mode == SPSA_MODE_A10) ? 4'(`SPSA_FRAME_10 - 1)
                                            : 4'(`SPSA_FRAME_11 - 1);

        // ==================================================================
        // Receive pin synchroniser and edge history
        n.sy1 = i_rxd;
        n.sy2 = r.sy1;
        n.sy3 = r.sy2;

        // ==================================================================
        // Sixteen-times baud tick
        tick = 1'b0;
        if (r.mode == SPSA_MODE_A11F) begin
            n.pre = r.pre + 2'h1;
            tick  = r.fast ? r.pre[0] : (r.pre == 2'h3);
        end else if (!sync_m) begin
            if (i_timer_ovf) begin
                n.half = ~r.half;
            end
            tick = i_timer_ovf && (r.fast || r.half);
        end

        // ==================================================================
        // Register writes
        if (wr_ctl) begin
            n.mode = spsa_mode_type'(i_wdata[`SPSA_CTL_MSH:`SPSA_CTL_MSL]);
            n.opt  = i_wdata[`SPSA_CTL_OPT];
            n.ren  = i_wdata[`SPSA_CTL_REN];
            n.tb8  = i_wdata[`SPSA_CTL_TB8];
            n.rb8  = i_wdata[`SPSA_CTL_RB8];
        end
        if (wr_cfg) begin
            n.fast = i_wdata[`SPSA_CFG_FAST];
        end

        // ==================================================================
        // Mode 0 shift engine
        // Buffer write wins over receive start
        if (sync_m && !r.m0_act) begin
            if (wr_buf) begin
                n.m0_act = 1'b1;
                n.m0_tx  = 1'b1;
                n.m0_sh  = i_wdata;
                n.m0_cnt = 4'h0;
                n.m0_bit = 3'h0;
                n.rxd_oe = 1'b1;
                n.rxd_o  = i_wdata[0];
            end else if (r.ren && !r.ri) begin
                n.m0_act = 1'b1;
                n.m0_tx  = 1'b0;
                n.m0_cnt = 4'h0;
                n.m0_bit = 3'h0;
                n.rxd_oe = 1'b0;
            end
        end else if (r.m0_act) begin
            n.m0_cnt = r.m0_cnt + 4'h1;
            if (r.m0_cnt == 4'h0) begin
                n.sclk = 1'b0;
                if (r.m0_tx && (r.m0_bit != 3'h0)) begin
                    n.m0_sh = {1'b0, r.m0_sh[7:1]};
                    n.rxd_o = r.m0_sh[1];
                end
            end
            if (r.m0_cnt == m0_half) begin
                n.sclk = 1'b1;
                if (!r.m0_tx) begin
                    n.m0_sh = {r.m0_sh[6:0], r.sy2};
                end
            end
            if (r.m0_cnt == m0_last) begin
                n.m0_cnt = 4'h0;
                n.m0_bit = r.m0_bit + 3'h1;
                if (r.m0_bit == 3'(`SPSA_BITS_M0 - 1)) begin
                    n.m0_act = 1'b0;
                    n.rxd_oe = 1'b0;
                    if (r.m0_tx) begin
                        ti_set = 1'b1;
                    end else begin
                        // First bit sits in bit 7
                        for (int i = 0; i < 8; i++) begin
                            rev[i] = r.m0_sh[7-i];
                        end
                        n.rbuf = rev;
                        ri_set = 1'b1;
                    end
                end
            end
        end

        // ==================================================================
        // Async transmitter, bit times follow its divide-by-16 counter
        roll = 1'b0;
        if (!sync_m && tick) begin
            n.tx_div = r.tx_div + 4'h1;
            roll     = (r.tx_div == 4'(`SPSA_SAMPLES - 1));
        end
        unique case (r.txst)
            SPSA_TX_IDLE: begin
                n.txd = 1'b1;
                if (wr_buf && !sync_m) begin
                    n.tx_sh = (r.mode == SPSA_MODE_A10) ?
                              {2'b11, i_wdata, 1'b0} :
                              {1'b1, r.tb8, i_wdata, 1'b0};
                    n.txst  = SPSA_TX_WAIT;
                end
            end
            SPSA_TX_WAIT: begin
                // Bit edges follow the divider
                if (roll) begin
                    n.txd     = r.tx_sh[0];
                    n.tx_sh   = {1'b1, r.tx_sh[10:1]};
                    n.tx_left = (r.mode == SPSA_MODE_A10) ? 4'(`SPSA_FRAME_10 - 1)
                                                          : 4'(`SPSA_FRAME_11 - 1);
                    n.txst    = SPSA_TX_SEND;
                end
            end
            SPSA_TX_SEND: begin
                if (roll) begin
                    if (r.tx_left == 4'h0) begin
                        n.txd  = 1'b1;
                        n.txst = SPSA_TX_IDLE;
                    end else begin
                        n.txd     = r.tx_sh[0];
                        n.tx_sh   = {1'b1, r.tx_sh[10:1]};
                        n.tx_left = r.tx_left - 4'h1;
                        if (r.tx_left == 4'h1) begin
                            ti_set = 1'b1;
                        end
                    end
                end
            end
            default: begin
                n.txst = SPSA_TX_IDLE;
            end
        endcase

        // ==================================================================
        // Async receiver
        unique case (r.rxst)
            SPSA_RX_HUNT: begin
                // Pin two clocks late, sy3 one more
                if (!sync_m && r.ren && r.sy3 && !r.sy2) begin
                    n.rx_div = 4'h0;
                    n.rx_idx = 4'h0;
                    n.rxst   = SPSA_RX_BITS;
                end
            end
            SPSA_RX_BITS: begin
                if (tick) begin
                    n.rx_div = r.rx_div + 4'h1;
                    if (r.rx_div == 4'(`SPSA_SAMPLE_A)) begin
                        n.rx_s[0] = r.sy2;
                    end
                    if (r.rx_div == 4'(`SPSA_SAMPLE_B)) begin
                        n.rx_s[1] = r.sy2;
                    end
                    if (r.rx_div == 4'(`SPSA_SAMPLE_C)) begin
                        bitv = (r.rx_s[0] & r.rx_s[1]) | (r.rx_s[0] & r.sy2)
                             | (r.rx_s[1] & r.sy2);
                        n.rx_idx = r.rx_idx + 4'h1;
                        if (r.rx_idx == 4'h0) begin
                            if (bitv) begin
                                n.rxst = SPSA_RX_HUNT;
                            end
                        end else if (r.rx_idx == rx_last) begin
                            keep = !r.ri && (!r.opt ||
                                   ((r.mode == SPSA_MODE_A10) ? bitv : r.rx9));
                            if (keep) begin
                                n.rbuf = r.rx_sh;
                                n.rb8  = (r.mode == SPSA_MODE_A10) ? bitv : r.rx9;
                                ri_set = 1'b1;
                            end
                            n.rxst = SPSA_RX_HUNT;
                        end else if (r.rx_idx == 4'(`SPSA_BITS_M0 + 1)) begin
                            n.rx9 = bitv;
                        end else begin
                            n.rx_sh = {bitv, r.rx_sh[7:1]};
                        end
                    end
                end
                // Leaving mode or enable drops the frame
                if (sync_m || !r.ren) begin
                    n.rxst = SPSA_RX_HUNT;
                end
            end
            default: begin
                n.rxst = SPSA_RX_HUNT;
            end
        endcase

        // ==================================================================
        // Flags: a hardware set wins over a software clear
        n.ti = ti_set || (wr_ctl ? i_wdata[`SPSA_CTL_TI] : r.ti);
        n.ri = ri_set || (wr_ctl ? i_wdata[`SPSA_CTL_RI] : r.ri);

        // ==================================================================
        // Pins and read data
        // Mode 0 shift clock on transmit pin
        n.txd_pin = sync_m ? n.sclk : n.txd;
        n.rdata   = 8'h00;
        if (i_rd) begin
            if (i_addr == AW'(`SPSA_OFF_CTL)) begin
                n.rdata = {r.mode, r.opt, r.ren, r.tb8, r.rb8, r.ti, r.ri};
            end else if (i_addr == AW'(`SPSA_OFF_BUF)) begin
                n.rdata = r.rbuf;
            end else if (i_addr == AW'(`SPSA_OFF_CFG)) begin
                n.rdata = {7'h00, r.fast};
            end
        end
    end

    // ======================================================================
    // State register
    always_ff @(posedge i_clk) begin
        if (!i_rst_n) begin
            r         <= '0;
            r.mode    <= spsa_mode_type'(2'(`SPSA_CTL_RST >> `SPSA_CTL_MSL));
            r.fast    <= `SPSA_CFG_RST;
            r.sy1     <= 1'b1;
            r.sy2     <= 1'b1;
            r.sy3     <= 1'b1;
            r.sclk    <= 1'b1;
            r.txd     <= 1'b1;
            r.txd_pin <= 1'b1;
            r.rxd_o   <= 1'b1;
            r.txst    <= SPSA_TX_IDLE;
            r.rxst    <= SPSA_RX_HUNT;
        end else begin
            r <= n;
        end
    end

    assign o_rdata  = r.rdata;
    assign o_rxd    = r.rxd_o;
    assign o_rxd_oe = r.rxd_oe;
    assign o_txd    = r.txd_pin;
    assign o_mode   = r.mode;

endmodule : spsa_serial_port
`default_nettype wire

//--- bench/spsa_serial_port_props.sv
// Concurrent checks on the serial port pins and register strobes
`timescale 1ns/1ps
`default_nettype none
module spsa_serial_port_props #(
    parameter int AW = 8
) (
    input wire logic                    i_clk,
    input wire logic                    i_rst_n,
    input wire logic [AW-1:0]           i_addr,
    input wire logic [7:0]              i_wdata,
    input wire logic                    i_wr,
    input wire logic                    i_rd,
    input wire logic [7:0]              o_rdata,
    input wire logic                    i_timer_ovf,
    input wire logic                    i_rxd,
    input wire logic                    o_rxd,
    input wire logic                    o_rxd_oe,
    input wire logic                    o_txd,
    input wire spsa_pkg::spsa_mode_type o_mode
);
    import spsa_pkg::*;
    // ======================================================================
    // Run lengths of the shift clock and drive enable
    logic       opt_r;
    logic [3:0] hi_r;
    logic [3:0] lo_r;
    logic [7:0] oe_r;
    always_ff @(posedge i_clk) begin
        if (!i_rst_n) begin
            opt_r <= 1'b0;
            hi_r  <= 4'h0;
            lo_r  <= 4'h0;
            oe_r  <= 8'h00;
        end else begin
            if (i_wr && i_addr == AW'(0)) begin
                opt_r <= i_wdata[5];
            end
            hi_r <= !o_txd ? 4'h0 : (hi_r == 4'hf) ? hi_r : hi_r + 4'h1;
            lo_r <= o_txd ? 4'h0 : lo_r + 4'h1;
            oe_r <= o_rxd_oe ? oe_r + 8'h01 : 8'h00;
        end
    end
    default clocking cb @(posedge i_clk);
    endclocking
    default disable iff (!i_rst_n);
    // ======================================================================
    // Properties
    mode_write_a: assert property (
        i_wr && i_addr == AW'(0) |=> o_mode == $past(i_wdata[7:6]))
        else $error("mode bits do not follow control write");
    m0_start_a: assert property (
        o_mode == SPSA_MODE_SYNC && hi_r == 4'hf && i_wr && i_addr == AW'(1)
        |=> o_rxd_oe && o_rxd == $past(i_wdata[0]))
        else $error("sync send did not start after buffer write");
    oe_len_a: assert property (
        $fell(o_rxd_oe) |-> oe_r == (opt_r ? 8'h20 : 8'h60))
        else $error("sync send not eight shift periods long");
    sclk_low_a: assert property (
        o_mode == SPSA_MODE_SYNC && $rose(o_txd) |-> lo_r == (opt_r ? 4'h2 : 4'h6))
        else $error("shift clock low phase wrong");
    sclk_high_a: assert property (
        o_mode == SPSA_MODE_SYNC && $fell(o_txd) && hi_r < 4'h7
        |-> hi_r == (opt_r ? 4'h2 : 4'h6))
        else $error("shift clock high phase wrong");
    rxd_edge_a: assert property (
        o_rxd_oe && $past(o_rxd_oe) && $changed(o_rxd) |-> $fell(o_txd))
        else $error("sync data changed off falling shift clock");
    rxd_dir_a: assert property (
        o_rxd_oe |-> o_mode == SPSA_MODE_SYNC)
        else $error("receive pin driven outside sync mode");
    rx_start_a: assert property (
        o_mode == SPSA_MODE_SYNC && hi_r == 4'hf && i_wr && i_addr == AW'(0)
        && i_wdata[7:6] == 2'h0 && i_wdata[4] && !i_wdata[0]
        |-> ##[1:4] (!o_txd && !o_rxd_oe))
        else $error("sync receive did not start");
    async_edge_a: assert property (
        o_mode == SPSA_MODE_A10 && $past(o_mode) == SPSA_MODE_A10 && $changed(o_txd)
        |-> $past(i_timer_ovf) || $past(i_timer_ovf, 2) || $past(i_timer_ovf, 3))
        else $error("async bit edge not aligned to baud tick");
endmodule : spsa_serial_port_props
bind spsa_serial_port spsa_serial_port_props #(.AW(AW)) u_props (
    .i_clk(i_clk), .i_rst_n(i_rst_n), .i_addr(i_addr), .i_wdata(i_wdata),
    .i_wr(i_wr), .i_rd(i_rd), .o_rdata(o_rdata), .i_timer_ovf(i_timer_ovf),
    .i_rxd(i_rxd), .o_rxd(o_rxd), .o_rxd_oe(o_rxd_oe), .o_txd(o_txd), .o_mode(o_mode)
);
`default_nettype wire

//--- bench/spsa_partner.sv
// Far side: external shift register and remote asynchronous station
`timescale 1ns/1ps
`default_nettype none
module spsa_partner #(
    parameter int BIT = 64
) (
    input  wire logic i_clk,
    input  wire logic i_sync,
    input  wire logic i_sclk,
    input  wire logic i_oe,
    input  wire logic i_line,
    output logic      o_drv
);
    logic [7:0] sh_r  = 8'h00;
    logic [7:0] got_r = 8'h00;
    int         n_r   = 8;
    initial o_drv = 1'b1;
    // ======================================================================
    // Shift register clocked by the device's shift clock
    always @(posedge i_sclk) begin
        if (i_sync) begin
            got_r = {i_line, got_r[7:1]};
            if (!i_oe && n_r < 8) begin
                n_r   = n_r + 1;
                sh_r  = sh_r >> 1;
                o_drv = (n_r < 8) ? sh_r[0] : ~o_drv;
            end
        end
    end
    task automatic load0(input logic [7:0] b);
        sh_r  = b;
        n_r   = 0;
        o_drv = b[0];
    endtask : load0
    // Remote transmitter opens each frame itself; a short pulse fakes a start
    task automatic send_async(input logic [7:0] b, input logic stop, input logic gl);
        logic [9:0] fr;
        fr = {stop, b, 1'b0};
        @(posedge i_clk) o_drv <= 1'b1;
        repeat (BIT) @(posedge i_clk);
        if (gl) begin
            o_drv <= 1'b0;
            repeat (BIT / 8) @(posedge i_clk);
            o_drv <= 1'b1;
            repeat (BIT * 2) @(posedge i_clk);
        end else begin
            for (int i = 0; i < 10; i++) begin
                o_drv <= fr[i];
                repeat (BIT) @(posedge i_clk);
            end
        end
    endtask : send_async
    task automatic recv_async(output logic [7:0] b, output logic stop);
        @(negedge i_sclk);
        repeat (BIT / 2) @(posedge i_clk);
        for (int i = 0; i < 8; i++) begin
            repeat (BIT) @(posedge i_clk);
            b[i] = i_sclk;
        end
        repeat (BIT) @(posedge i_clk);
        stop = i_sclk;
    endtask : recv_async
endmodule : spsa_partner
`default_nettype wire

//--- bench/serial_port_sync_async_tb.sv
// Self-checking bench of the serial port in sync and async modes
`timescale 1ns/1ps
`default_nettype none
module serial_port_sync_async_tb;
    import spsa_pkg::*;
    logic          clk   = 1'b0;
    logic          rst_n = 1'b0;
    logic [7:0]    addr  = 8'h00;
    logic [7:0]    wdata = 8'h00;
    logic          wr    = 1'b0;
    logic          rd    = 1'b0;
    logic          ovf   = 1'b0;
    logic [1:0]    tk    = 2'h0;
    logic [31:0]   seed  = 32'h23;
    logic [7:0]    rdata;
    logic          txd;
    logic          rxd_o;
    logic          oe;
    logic          drv;
    logic          line;
    spsa_mode_type mode;
    int            err_total = 0;
    int            samples_checked = 0;
    int            cyc = 0;
    assign line = oe ? rxd_o : drv;
    always #5 clk = ~clk;
    // Baud tick every fourth clock
    always @(posedge clk) begin
        tk  <= tk + 2'h1;
        ovf <= (tk == 2'h3);
    end
    spsa_serial_port #(.AW(8)) dut (
        .i_clk(clk), .i_rst_n(rst_n), .i_addr(addr), .i_wdata(wdata), .i_wr(wr),
        .i_rd(rd), .o_rdata(rdata), .i_timer_ovf(ovf), .i_rxd(line), .o_rxd(rxd_o),
        .o_rxd_oe(oe), .o_txd(txd), .o_mode(mode)
    );
    spsa_partner #(.BIT(64)) p (
        .i_clk(clk), .i_sync(mode == SPSA_MODE_SYNC), .i_sclk(txd), .i_oe(oe),
        .i_line(line), .o_drv(drv)
    );
    // ======================================================================
    // Helpers
    function automatic logic [7:0] ctl(input logic [1:0] m, input logic opt, input logic ren);
        return {m, opt, ren, 4'h0};
    endfunction : ctl
    function automatic logic keep(input logic opt, input logic stop, input logic gl);
        return !gl && (!opt || stop);
    endfunction : keep
    task automatic rnd(output logic [7:0] v);
        seed = seed ^ (seed << 13);
        seed = seed ^ (seed >> 17);
        seed = seed ^ (seed << 5);
        v = seed[7:0];
    endtask : rnd
    task automatic wr_reg(input logic [7:0] a, input logic [7:0] d);
        @(posedge clk);
        wr    <= 1'b1;
        addr  <= a;
        wdata <= d;
        @(posedge clk);
        wr    <= 1'b0;
    endtask : wr_reg
    task automatic rd_reg(input logic [7:0] a, output logic [7:0] d);
        @(posedge clk);
        rd   <= 1'b1;
        addr <= a;
        @(posedge clk);
        rd   <= 1'b0;
        #1 d = rdata;
    endtask : rd_reg
    task automatic chk(input logic [7:0] seen, input logic [7:0] exp);
        samples_checked++;
        if (seen !== exp) begin
            err_total++;
            $display("mismatch at %0t: seen %h expected %h", $time, seen, exp);
        end
    endtask : chk
    task automatic wait_flag(input logic [7:0] m, output logic [7:0] d);
        d = 8'h00;
        for (int n = 0; n < 400 && (d & m) == 8'h00; n++) begin
            rd_reg(8'h00, d);
        end
    endtask : wait_flag
    task automatic end_sim();
        $display("checks %0d mismatches %0d", samples_checked, err_total);
        if (err_total == 0 && samples_checked > 0) begin
            $display("TEST PASSED");
        end else begin
            $display("TEST FAILED");
        end
        $finish;
    endtask : end_sim
    always @(posedge clk) begin
        cyc <= cyc + 1;
        if (cyc == 40000) begin
            err_total++;
            end_sim();
        end
    end
    // ======================================================================
    // Main sequence
    initial begin
        logic [7:0] d, b, b0;
        logic       s, opt, stop, gl, quiet;
        repeat (3) @(posedge clk);
        rst_n <= 1'b1;
        rd_reg(8'h00, d); chk(d, 8'h00);
        rd_reg(8'h02, d); chk(d, 8'h01);
        wr_reg(8'h03, 8'hff); rd_reg(8'h03, d); chk(d, 8'h00);
        for (int k = 0; k < 4; k++) begin
            wr_reg(8'h00, ctl(k[1:0], 1'b0, 1'b0));
            rd_reg(8'h00, d); chk({6'h0, mode}, k[7:0]);
        end
        $display("mode select done");
        for (int k = 0; k < 4; k++) begin
            rnd(b);
            if (k == 0) b = 8'h80;
            wr_reg(8'h00, ctl(2'h0, k[0], 1'b0));
            repeat (16) @(posedge clk);
            wr_reg(8'h01, b);
            wait_flag(8'h02, d);
            chk(d & 8'h02, 8'h02);
            chk(p.got_r, b);
        end
        $display("sync send done");
        for (int k = 0; k < 2; k++) begin
            rnd(b);
            p.load0(b);
            wr_reg(8'h00, ctl(2'h0, k[0], 1'b1));
            wait_flag(8'h01, d);
            rd_reg(8'h01, d); chk(d, b);
            quiet = 1'b1;
            repeat (40) @(posedge clk) if (!txd) quiet = 1'b0;
            chk({7'h0, quiet}, 8'h01);
        end
        $display("sync receive done");
        wr_reg(8'h00, ctl(2'h1, 1'b0, 1'b0));
        for (int k = 0; k < 2; k++) begin
            rnd(b);
            wr_reg(8'h01, b);
            p.recv_async(d, s);
            chk(d, b);
            chk({7'h0, s}, 8'h01);
            rd_reg(8'h00, d); chk(d & 8'h02, 8'h02);
            wr_reg(8'h00, ctl(2'h1, 1'b0, 1'b0));
            repeat (80) @(posedge clk);
        end
        $display("async send done");
        wr_reg(8'h00, 8'hc0);
        rnd(b);
        wr_reg(8'h01, b);
        p.recv_async(d, s);
        chk(d, b);
        chk({7'h0, s}, 8'h00);
        repeat (160) @(posedge clk);
        $display("mode 3 send done");
        b0 = 8'h00;
        for (int k = 0; k < 5; k++) begin
            rnd(b);
            opt  = (k >= 2);
            stop = (k != 1) && (k != 2);
            gl   = (k == 3);
            wr_reg(8'h00, ctl(2'h1, opt, 1'b1));
            p.send_async(b, stop, gl);
            repeat (8) @(posedge clk);
            rd_reg(8'h00, d); chk({7'h0, d[0]}, {7'h0, keep(opt, stop, gl)});
            if (keep(opt, stop, gl)) begin
                chk({7'h0, d[2]}, {7'h0, stop});
                rd_reg(8'h01, d); chk(d, b);
                b0 = b;
            end
        end
        p.send_async(~b0, 1'b1, 1'b0);
        repeat (8) @(posedge clk);
        rd_reg(8'h01, d); chk(d, b0);
        $display("async receive done");
        end_sim();
    end
endmodule : serial_port_sync_async_tb
`default_nettype wire
